//--- shared/twm_pkg.sv
package twm_pkg;

	// Register byte offsets
	localparam logic [3:0] TWM_OFF_CTRL   = 4'h0;
	localparam logic [3:0] TWM_OFF_DATA   = 4'h4;
	localparam logic [3:0] TWM_OFF_STATUS = 4'h8;
	localparam logic [3:0] TWM_OFF_DIV    = 4'hC;

	// Control register bit positions
	localparam int TWM_BIT_AA  = 2;
	localparam int TWM_BIT_SI  = 3;
	localparam int TWM_BIT_STO = 4;
	localparam int TWM_BIT_STA = 5;
	localparam int TWM_BIT_EN  = 6;

	// Reset values
	localparam logic [7:0]  TWM_RST_CTRL   = 8'h00;
	localparam logic [7:0]  TWM_RST_STATUS = 8'hF8;
	localparam logic [15:0] TWM_RST_DIV    = 16'h007D;

	// Status codes
	localparam logic [7:0] TWM_ST_START  = 8'h08;
	localparam logic [7:0] TWM_ST_RSTART = 8'h10;
	localparam logic [7:0] TWM_ST_AW_ACK = 8'h18;
	localparam logic [7:0] TWM_ST_AW_NAK = 8'h20;
	localparam logic [7:0] TWM_ST_DW_ACK = 8'h28;
	localparam logic [7:0] TWM_ST_DW_NAK = 8'h30;
	localparam logic [7:0] TWM_ST_ARB    = 8'h38;
	localparam logic [7:0] TWM_ST_AR_ACK = 8'h40;
	localparam logic [7:0] TWM_ST_AR_NAK = 8'h48;
	localparam logic [7:0] TWM_ST_DR_ACK = 8'h50;
	localparam logic [7:0] TWM_ST_DR_NAK = 8'h58;
	localparam logic [7:0] TWM_ST_IDLE   = 8'hF8;

	// Bus phase sequencing
	localparam logic [3:0] TWM_BITS_ACK = 4'd8;

	typedef enum logic [3:0] {
		TWM_S_IDLE   = 4'b0000,
		TWM_S_WAIT   = 4'b0001,
		TWM_S_START  = 4'b0010,
		TWM_S_BIT    = 4'b0011,
		TWM_S_STOP   = 4'b0100,
		TWM_S_BFREE  = 4'b0101,
		TWM_S_HOLD   = 4'b0110
	} twm_state_t;

	// Control fields as software sees them
	typedef struct packed {
		logic en;
		logic sta;
		logic sto;
		logic si;
		logic aa;
	} twm_ctrl_t;

endpackage : twm_pkg

//--- logic/twm_engine.sv
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
// What this block does
// - After start report 08h, send write address
// - After 08h send read-direction address too
// - Repeated start reports 10h; read switches receiver
// - 10h with write address switches to transmitter
// - Transmit statuses: new byte shifted out
// - Start without stop gives repeated start
// - Stop alone sends stop, clears stop bit
// - Start plus stop: stop, start, clear stop
// - Write address not acknowledged reports 20h
// - Data not acknowledged 30h, acknowledged 28h
// - Arbitration lost 38h; release, go unaddressed
// - After 38h with start: wait free, start
// - Receiver arbitration loss also reports 38h
// - After 40h/50h receive byte, ack if set
// - Acknowledge bit clear returns not-acknowledge
// - Read address not acknowledged reports 48h
// - Acked received byte reports 50h
// - Not-acked received byte reports 58h
module twm_engine
	import twm_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Two-wire pins
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe
);

	twm_state_t  state_r, state_nxt;
	twm_ctrl_t   ctrl_r;
	logic [7:0]  data_r;
	logic [7:0]  status_r;
	logic [15:0] div_r;
	logic [15:0] cnt_r;
	logic [1:0]  ph_r;
	logic [3:0]  bit_r;
	logic        addr_ph_r;
	logic        rx_mode_r;
	logic        stop_then_start_r;
	logic        rep_start_r;
	logic        scl_oe_r, sda_oe_r;
	logic [2:0]  scl_s_r, sda_s_r;
	logic        scl_q_r, sda_q_r;
	logic [31:0] rdata_r;
	logic        wait_r;

	// Pin synchronisers: change counts when stages 2 and 3 agree
	always_ff @(posedge core_clk) begin
		scl_s_r <= {scl_s_r[1:0], scl_in};
		sda_s_r <= {sda_s_r[1:0], sda_in};
		if (rst) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			if (scl_s_r[1] == scl_s_r[2])
				scl_q_r <= scl_s_r[2];
			if (sda_s_r[1] == sda_s_r[2])
				sda_q_r <= sda_s_r[2];
		end
	end

	// Bus-free tracking: start seen sets busy, stop seen clears it
	logic sda_prev_r, bus_busy_r;
	wire  start_seen = scl_q_r && sda_prev_r && !sda_q_r;
	wire  stop_seen  = scl_q_r && !sda_prev_r && sda_q_r;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sda_prev_r <= 1'b1;
			bus_busy_r <= 1'b0;
		end else begin
			sda_prev_r <= sda_q_r;
			if (start_seen)
				bus_busy_r <= 1'b1;
			else if (stop_seen)
				bus_busy_r <= 1'b0;
		end
	end

	// Bus decode
	wire acc      = (avs_read || avs_write) && wait_r;
	wire wr_ctrl  = avs_write && !wait_r && avs_address == TWM_OFF_CTRL
			&& avs_byteenable[0];
	wire wr_data  = avs_write && !wait_r && avs_address == TWM_OFF_DATA
			&& avs_byteenable[0];
	wire wr_div   = avs_write && !wait_r && avs_address == TWM_OFF_DIV;
	wire [7:0] ctrl_rd = {1'b0, ctrl_r.en, ctrl_r.sta, ctrl_r.sto,
			ctrl_r.si, ctrl_r.aa, 2'b00};
	wire [31:0] rd_mux =
		(avs_address == TWM_OFF_CTRL)   ? {24'h000000, ctrl_rd} :
		(avs_address == TWM_OFF_DATA)   ? {24'h000000, data_r} :
		(avs_address == TWM_OFF_STATUS) ? {24'h000000, status_r} :
		(avs_address == TWM_OFF_DIV)    ? {16'h0000, div_r} :
		32'h00000000;

	// One wait state per access, then answer
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h00000000;
		end else begin
			wait_r  <= !acc;
			if (acc)
				rdata_r <= rd_mux;
		end
	end

	// Quarter-bit timing tick
	wire tick = (cnt_r == 16'h0000);
	// Stretch: wait while a slave holds clock low
	wire stretched = ph_r == 2'd2 && scl_oe_r == 1'b0 && !scl_q_r;
	always_ff @(posedge core_clk) begin
		if (rst || state_r == TWM_S_WAIT || state_r == TWM_S_IDLE)
			cnt_r <= div_r;
		else if (tick && !stretched)
			cnt_r <= div_r;
		else if (!tick)
			cnt_r <= cnt_r - 16'h0001;
	end

	// Events from the bit engine
	logic       ev;
	logic [7:0] ev_code;
	// Received data bits are driven by the slave, so they never arbitrate
	wire  sda_drive_bit = (addr_ph_r || !rx_mode_r) ? data_r[7] : 1'b0;
	wire  ack_bit_val   = (bit_r == TWM_BITS_ACK);
	// Arbitration lost: released SDA high, but line read low
	wire  arb_lost = tick && ph_r == 2'd2 && !sda_oe_r && !sda_q_r
			&& (bit_r != TWM_BITS_ACK ? sda_drive_bit
			    : (rx_mode_r && !addr_ph_r && !ctrl_r.aa));
	wire  go = state_r == TWM_S_HOLD && !ctrl_r.si;

	always_comb begin
		state_nxt = state_r;
		ev        = 1'b0;
		ev_code   = status_r;
		case (state_r)
			TWM_S_IDLE: begin
				if (ctrl_r.en && ctrl_r.sta && !ctrl_r.si)
					state_nxt = bus_busy_r ? TWM_S_BFREE : TWM_S_START;
			end
			TWM_S_BFREE: begin
				if (!bus_busy_r)
					state_nxt = TWM_S_START;
			end
			TWM_S_START: begin
				if (tick && ph_r == 2'd3) begin
					state_nxt = TWM_S_HOLD;
					ev = 1'b1;
					ev_code = rep_start_r
						? TWM_ST_RSTART : TWM_ST_START;
				end
			end
			TWM_S_BIT: begin
				if (arb_lost) begin
					state_nxt = TWM_S_HOLD;
					ev = 1'b1;
					ev_code = TWM_ST_ARB;
				end else if (tick && ph_r == 2'd3 && ack_bit_val) begin
					state_nxt = TWM_S_HOLD;
					ev = 1'b1;
					if (addr_ph_r)
						ev_code = rx_mode_r
							? (sda_q_r ? TWM_ST_AR_NAK : TWM_ST_AR_ACK)
							: (sda_q_r ? TWM_ST_AW_NAK : TWM_ST_AW_ACK);
					else if (rx_mode_r)
						ev_code = ctrl_r.aa ? TWM_ST_DR_ACK : TWM_ST_DR_NAK;
					else
						ev_code = sda_q_r ? TWM_ST_DW_NAK : TWM_ST_DW_ACK;
				end
			end
			TWM_S_STOP: begin
				if (tick && ph_r == 2'd3)
					state_nxt = stop_then_start_r ? TWM_S_START : TWM_S_IDLE;
			end
			TWM_S_HOLD: begin
				if (go) begin
					if (ctrl_r.sto)
						state_nxt = TWM_S_STOP;
					else if (ctrl_r.sta)
						state_nxt = status_r == TWM_ST_ARB
							? (bus_busy_r ? TWM_S_BFREE : TWM_S_START)
							: TWM_S_START;
					else if (status_r == TWM_ST_ARB)
						state_nxt = TWM_S_IDLE;
					else if (status_r == TWM_ST_AR_NAK
						|| status_r == TWM_ST_DR_NAK)
						state_nxt = TWM_S_IDLE;
					else
						state_nxt = TWM_S_BIT;
				end
			end
			default: state_nxt = TWM_S_IDLE;
		endcase
	end

	// Shared decodes for the register and bit engines
	wire in_start  = state_r == TWM_S_START;
	wire in_bit    = state_r == TWM_S_BIT;
	wire in_stop   = state_r == TWM_S_STOP;
	wire moving    = in_start || in_stop || in_bit;
	wire adv       = tick && !stretched;
	wire at_end    = tick && ph_r == 2'd3;
	wire stop_done = in_stop && at_end;
	wire bit_end   = in_bit && ph_r == 2'd3 && adv;
	wire was_start = status_r == TWM_ST_START
			|| status_r == TWM_ST_RSTART;
	wire to_byte   = go && !ctrl_r.sto && !ctrl_r.sta
			&& status_r != TWM_ST_ARB;
	wire rep_req   = ctrl_r.sta && !ctrl_r.sto
			&& status_r != TWM_ST_ARB;
	wire rx_shift  = !addr_ph_r && rx_mode_r;
	wire in_byte   = bit_r < TWM_BITS_ACK;
	wire [7:0] data_shift = rx_shift ? {data_r[6:0], sda_q_r}
			: {data_r[6:0], data_r[7]};
	wire si_wr     = ev || (ctrl_r.si && avs_writedata[TWM_BIT_SI]);
	wire ack_drive = rx_shift && ctrl_r.aa;
	wire bit_drive = (addr_ph_r || !rx_mode_r) && !data_r[7];
	// Start keeps the clock low until data is let go, so that a
	// repeated start never looks like a stop on the wire
	wire scl_start = (ph_r == 2'd0 && !tick && scl_oe_r)
			|| (ph_r == 2'd3 && tick);
	wire scl_bit   = !(ph_r == 2'd1 && tick)
			&& (ph_r == 2'd0 || (ph_r == 2'd3 && tick) || scl_oe_r);
	wire scl_stop  = ph_r == 2'd0 && !tick;
	// Hold keeps the clock low, except to give the bus up after a loss
	wire scl_hold  = !(go && status_r == TWM_ST_ARB);

	// Control bits: a new status sets the flag even against a write
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_r <= twm_ctrl_t'(TWM_RST_CTRL[4:0]);
		end else begin
			if (wr_ctrl) begin
				ctrl_r.en  <= avs_writedata[TWM_BIT_EN];
				ctrl_r.sta <= avs_writedata[TWM_BIT_STA];
				ctrl_r.sto <= avs_writedata[TWM_BIT_STO];
				ctrl_r.aa  <= avs_writedata[TWM_BIT_AA];
				ctrl_r.si  <= si_wr;
			end else if (ev) begin
				ctrl_r.si <= 1'b1;
			end
			if (stop_done)
				ctrl_r.sto <= 1'b0;
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (rst)
			state_r <= TWM_S_IDLE;
		else
			state_r <= state_nxt;
	end

	// Data, status and divider; shifting wins over a bus write
	always_ff @(posedge core_clk) begin
		if (rst) begin
			data_r   <= 8'h00;
			status_r <= TWM_RST_STATUS;
			div_r    <= TWM_RST_DIV;
		end else begin
			if (wr_div)
				div_r <= avs_writedata[15:0];
			if (wr_data)
				data_r <= avs_writedata[7:0];
			if (bit_end && in_byte)
				data_r <= data_shift;
			if (ev)
				status_r <= ev_code;
		end
	end

	// Transfer mode, and whether the next start is a repeated one
	always_ff @(posedge core_clk) begin
		if (rst) begin
			addr_ph_r         <= 1'b0;
			rx_mode_r         <= 1'b0;
			stop_then_start_r <= 1'b0;
			rep_start_r       <= 1'b0;
		end else begin
			if (go) begin
				stop_then_start_r <= ctrl_r.sto && ctrl_r.sta;
				rep_start_r       <= rep_req;
			end else if (state_r == TWM_S_IDLE) begin
				rep_start_r <= 1'b0;
			end
			if (to_byte) begin
				addr_ph_r <= was_start;
				if (was_start)
					rx_mode_r <= data_r[0];
			end
		end
	end

	// Quarter-bit phase and bit counter
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ph_r  <= 2'd0;
			bit_r <= 4'd0;
		end else if (to_byte) begin
			ph_r  <= 2'd0;
			bit_r <= 4'd0;
		end else if (moving) begin
			if (adv)
				ph_r <= ph_r + 2'd1;
			if (bit_end)
				bit_r <= bit_r + 4'd1;
		end else begin
			ph_r <= 2'd0;
		end
	end

	// Open-drain drive: an enable pulls its line low
	always_ff @(posedge core_clk) begin
		if (rst) begin
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else begin
			case (state_r)
				TWM_S_START: scl_oe_r <= scl_start;
				TWM_S_BIT:   scl_oe_r <= scl_bit;
				TWM_S_STOP:  scl_oe_r <= scl_stop;
				TWM_S_HOLD:  scl_oe_r <= scl_hold;
				default:     scl_oe_r <= 1'b0;
			endcase
			case (state_r)
				TWM_S_START: sda_oe_r <= ph_r >= 2'd2;
				TWM_S_BIT:   sda_oe_r <= ack_bit_val
					? ack_drive
					: bit_drive;
				TWM_S_STOP:  sda_oe_r <= ph_r <= 2'd1;
				TWM_S_HOLD:  sda_oe_r <= sda_oe_r
					&& status_r != TWM_ST_ARB;
				default:     sda_oe_r <= 1'b0;
			endcase
		end
	end

	// Outputs straight from flops, pin data outputs tied low
	assign avs_readdata    = rdata_r;
	assign avs_waitrequest = wait_r;
	assign scl_oe  = scl_oe_r;
	assign sda_oe  = sda_oe_r;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;

endmodule : twm_engine

//--- sim/twm_engine_sva.sv
`timescale 1ns/1ps
module twm_engine_sva
	import twm_pkg::*;
(
	// Clock
	input wire logic        core_clk,
	input wire logic        rst,
	// Bus
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Pins
	input wire logic        scl_out,
	input wire logic        scl_oe,
	input wire logic        sda_out,
	input wire logic        sda_oe
);
	wire rd_done = avs_read && !avs_waitrequest;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	a_bus_answer: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest) else $error("late answer");
	a_wait_back: assert property (!avs_waitrequest
		|=> avs_waitrequest) else $error("answer too long");
	a_reset_quiet: assert property (disable iff (1'b0) rst |=>
		avs_waitrequest && !scl_oe && !sda_oe) else $error("busy in reset");
	a_open_drain: assert property (!scl_out && !sda_out)
		else $error("pin driven high");
	a_gap_zero: assert property (rd_done && avs_address[1:0] != 2'h0
		|-> avs_readdata == 32'h0) else $error("gap not zero");
	a_status_form: assert property (rd_done &&
		avs_address == TWM_OFF_STATUS |-> avs_readdata[2:0] == 3'h0 &&
		avs_readdata[31:8] == 24'h0) else $error("bad status form");
	a_stop_hold: assert property ($fell(sda_oe) && !scl_oe &&
		!$past(scl_oe) |=> (!sda_oe) [*2]) else $error("stop too short");
	a_start_hold: assert property ($rose(sda_oe) && !scl_oe &&
		!$past(scl_oe) |=> sda_oe [*2]) else $error("start too short");
endmodule : twm_engine_sva
bind twm_engine twm_engine_sva twm_engine_sva_inst (.core_clk, .rst,
	.avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
	.scl_out, .scl_oe, .sda_out, .sda_oe);

//--- sim/twm_slave_model.sv
`timescale 1ns/1ps
module twm_slave_model #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	// Lines
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            scl_oe = 0,
	output logic            sda_oe = 0,
	// Controls
	input  wire logic       stretch,
	input  wire logic       nak_data,
	input  wire logic [7:0] tx_byte,
	output logic      [7:0] rx_byte
);
	logic [7:0] sh;
	int         cnt = 0;
	logic       act = 0;
	logic       first = 0;
	logic       rd = 0;
	logic       tx = 0;
	always @(negedge sda) if (scl) begin
		cnt = 0;
		first = 1;
		act = 1;
		tx = 0;
	end
	always @(posedge sda) if (scl) act = 0;
	always @(posedge scl) if (act) begin
		sh = {sh[6:0], sda};
		cnt++;
	end
	always @(negedge scl) if (act) begin
		sda_oe = 0;
		if (cnt == 8 && first) begin
			rd = sh[0];
			first = 0;
			act = (sh[7:1] == ADDR);
			sda_oe = act;
		end else if (cnt == 8 && !rd) begin
			rx_byte = sh;
			sda_oe = !nak_data;
		end else if (cnt == 9) begin
			cnt = 0;
			tx = rd && !sh[0];
		end
		if (tx && cnt < 8)
			sda_oe = !tx_byte[7 - cnt];
		if (cnt == 1 && stretch) begin
			scl_oe = 1;
			#400;
			scl_oe = 0;
		end
	end
endmodule : twm_slave_model

//--- sim/twm_engine_test.sv
`timescale 1ns/1ps
module twm_engine_test
	import twm_pkg::*;
;
	logic        core_clk = 0;
	logic        rst = 1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 0;
	logic        avs_write = 0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [31:0] q;
	logic        scl_oe;
	logic        sda_oe;
	logic        s_scl_oe;
	logic        s_sda_oe;
	logic        tb_sda_oe = 0;
	logic        stretch = 0;
	logic        nak_data = 0;
	logic [7:0]  rx_byte;
	int          fail_count = 0;
	int          n_tests = 0;
	int          cyc = 0;
	wire         scl_w = !(scl_oe || s_scl_oe);
	wire         sda_w = !(sda_oe || s_sda_oe || tb_sda_oe);
	always #4 core_clk = !core_clk;
	twm_engine twm_engine_inst (.core_clk, .rst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
		.avs_waitrequest, .scl_in(scl_w), .scl_out(), .scl_oe,
		.sda_in(sda_w), .sda_out(), .sda_oe);
	twm_slave_model twm_slave_model_inst (.scl(scl_w), .sda(sda_w),
		.scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .stretch, .nak_data,
		.tx_byte(8'hC3), .rx_byte);
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value at %0t: %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		@(posedge core_clk);
	endtask : bus
	task automatic go(input logic [7:0] c, input logic [7:0] e);
		int n;
		n = 0;
		bus(1, TWM_OFF_CTRL, c);
		do begin
			bus(0, TWM_OFF_CTRL, 8'h00);
			n++;
		end while (q[TWM_BIT_SI] !== 1'b1 && n < 2000);
		bus(0, TWM_OFF_STATUS, 8'h00);
		chk(q, {24'h0, e});
	endtask : go
	task automatic snd(input logic [7:0] d, input logic [7:0] e);
		bus(1, TWM_OFF_DATA, d);
		go(8'h40, e);
	endtask : snd
	task automatic stop_wait;
		int n;
		n = 0;
		bus(1, TWM_OFF_CTRL, 8'h50);
		do begin
			bus(0, TWM_OFF_CTRL, 8'h00);
			n++;
		end while (q[TWM_BIT_STO] !== 1'b0 && n < 500);
		repeat (40) @(posedge core_clk);
		chk({scl_oe, sda_oe, q[TWM_BIT_STO]}, 32'h0);
	endtask : stop_wait
	task automatic t_write;
		bus(1, TWM_OFF_DIV, 8'h03);
		go(8'h60, 8'h08);
		snd(8'h54, 8'h18);
		snd(8'hA5, 8'h28);
		chk(rx_byte, 8'hA5);
		nak_data <= 1;
		snd(8'h3C, 8'h30);
		nak_data <= 0;
		chk(rx_byte, 8'h3C);
		stop_wait();
		$display("write test done");
	endtask : t_write
	task automatic t_read;
		stretch <= 1;
		go(8'h60, 8'h08);
		snd(8'h20, 8'h20);
		go(8'h60, 8'h10);
		snd(8'h55, 8'h40);
		go(8'h44, 8'h50);
		bus(0, TWM_OFF_DATA, 8'h00);
		chk(q, 32'hC3);
		go(8'h40, 8'h58);
		bus(0, TWM_OFF_DATA, 8'h00);
		chk(q, 32'hC3);
		go(8'h60, 8'h10);
		snd(8'h54, 8'h18);
		go(8'h70, 8'h08);
		bus(0, TWM_OFF_CTRL, 8'h00);
		chk(q[TWM_BIT_STO], 1'b0);
		snd(8'h57, 8'h48);
		stop_wait();
		stretch <= 0;
		$display("read test done");
	endtask : t_read
	task automatic t_arb;
		go(8'h60, 8'h08);
		tb_sda_oe <= 1;
		snd(8'hFE, 8'h38);
		bus(1, TWM_OFF_CTRL, 8'h60);
		repeat (40) @(posedge core_clk);
		chk({scl_oe, sda_oe}, 32'h0);
		tb_sda_oe <= 0;
		go(8'h60, 8'h08);
		stop_wait();
		$display("arbitration test done");
	endtask : t_arb
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			wrap_up();
		end
	end
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 0;
		@(posedge core_clk);
		bus(0, TWM_OFF_STATUS, 8'h00);
		chk(q, 32'hF8);
		bus(0, 4'h2, 8'h00);
		chk(q, 32'h0);
		t_write();
		t_read();
		t_arb();
		wrap_up();
	end
endmodule : twm_engine_test
